// ==== hw/osc_ctl_pkg.sv ====
// Constants and carrier types for the oscillator selection control block
package osc_ctl_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses) and alias codes
    // ------------------------------------------------------------------
    localparam logic [15:0] OFF_OSC_CTL   = 16'hF000;
    localparam logic [15:0] OFF_FRC_TUNE  = 16'hF010;
    localparam logic [15:0] OFF_REF_CTL   = 16'hF020;
    localparam logic [15:0] OFF_REF_TRIM  = 16'hF030;
    localparam logic [15:0] OFF_UNLOCK    = 16'hF040;
    localparam logic [1:0]  ALIAS_WRITE   = 2'h0;
    localparam logic [1:0]  ALIAS_CLR     = 2'h1;
    localparam logic [1:0]  ALIAS_SET     = 2'h2;
    localparam logic [1:0]  ALIAS_INV     = 2'h3;

    // ------------------------------------------------------------------
    // Oscillator control field positions
    // ------------------------------------------------------------------
    localparam int POS_PLL_POST_DIV = 27;
    localparam int POS_FAST_RC_DIV  = 24;
    localparam int POS_SOSC_READY   = 22;
    localparam int POS_PB_WRITE_OK  = 21;
    localparam int POS_PB_DIVISOR   = 19;
    localparam int POS_PLL_MULT     = 16;
    localparam int POS_CUR_SOURCE   = 12;
    localparam int POS_NEXT_SOURCE  = 8;
    localparam int POS_FREEZE       = 7;
    localparam int POS_USB_LOCKED   = 6;
    localparam int POS_SYS_LOCKED   = 5;
    localparam int POS_SLEEP_WAIT   = 4;
    localparam int POS_CLOCK_FAIL   = 3;
    localparam int POS_USB_FROM_RC  = 2;
    localparam int POS_SOSC_ENABLE  = 1;
    localparam int POS_SWITCH_REQ   = 0;

    // Writable bits, frozen selection bits, divisor bits, reset values
    localparam logic [31:0] OSC_WR_MASK   = 32'h3F1F079F;
    localparam logic [31:0] OSC_FRZ_MASK  = 32'h3F070701;
    localparam logic [31:0] OSC_PB_MASK   = 32'h00180000;
    localparam logic [31:0] OSC_RESET     = 32'h01000000;
    localparam logic [31:0] TUNE_WR_MASK  = 32'h0000003F;
    localparam logic [31:0] REF_WR_MASK   = 32'h7FFFBA0F;
    localparam logic [31:0] REF_HC_MASK   = 32'h00000200;
    localparam logic [31:0] TRIM_WR_MASK  = 32'hFF800000;
    localparam logic [31:0] REG_RESET     = 32'h00000000;

    // Unlock keys, written in this order to the unlock register
    localparam logic [31:0] UNLOCK_KEY1   = 32'h0000C1A5;
    localparam logic [31:0] UNLOCK_KEY2   = 32'h00005A3C;

    // Divisor settle time after a change, in ns, and in cycles at 200 MHz
    localparam int CLK_PERIOD_PS     = 5000;
    localparam int PB_SETTLE_NS      = 20;
    localparam int PB_SETTLE_CYC_INT =
        (PB_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] PB_SETTLE_CYC = 4'(PB_SETTLE_CYC_INT);

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] switch_monitor_fuse;
        logic [2:0] initial_source_fuse;
        logic [2:0] pll_post_divider;
        logic [2:0] pll_multiplier;
        logic [1:0] periph_bus_divisor;
        logic       secondary_osc_enable;
    } fuse_t;

    typedef struct packed {
        logic sosc_stable;
        logic sys_pll_locked;
        logic usb_pll_locked;
        logic clock_failed;
        logic source_ready;
    } osc_status_t;

    typedef struct packed {
        logic [2:0] active_source;
        logic [2:0] requested_source;
        logic       switch_busy;
        logic [8:0] pll_post_div_ratio;
        logic [8:0] fast_rc_div_ratio;
        logic [3:0] periph_div_ratio;
        logic [4:0] pll_mult_factor;
        logic       secondary_osc_enable;
        logic       usb_clock_from_rc;
        logic [5:0] rc_trim_field;
        logic       enter_sleep;
        logic       enter_idle;
    } clk_cfg_t;

endpackage

// ==== hw/osc_select_ctl.sv ====
// APB slave holding the oscillator selection and clock divider registers
//
// Function
// - PLL post divider code 0..7 divides by 1,2,4,8,16,32,64,256.
// - Fast RC divider code 0..7 divides likewise; resets to divide by two.
// - Secondary oscillator ready reads one only while it runs stably.
// - Read-only flag tells whether the bus divisor may be written now.
// - Bus divisor codes 0..3 divide system clock by 1,2,4,8.
// - PLL multiplier codes select 15,16,17,18,19,20,21,24.
// - Read-only current source field reports the active clock.
// - Next source loads from the initial source fuse at reset.
// - Monitor fuse 1x: freeze bit locks clock and PLL selections.
// - Monitor fuse 0x: selections are never locked.
// - USB PLL lock flag is read-only, one when locked.
// - System PLL lock flag is read-only, one when locked.
// - Sleep-on-wait one: wait enters Sleep; zero: enters Idle.
// - Clear, set and invert aliases sit at offsets 4, 8, C.
// - Oscillator control ignores writes without the unlock sequence.
// - Unimplemented bits read zero; trim field bits 5:0, reset zero.
// - Clock fail bit sets on a detected clock failure.
// - Switch request starts a switch; hardware clears it on completion.
// - Secondary oscillator enable turns that oscillator on or off.
// - USB clock select picks fast RC when one, else primary or PLL.
`timescale 1ns/1ps

module osc_select_ctl #(
    parameter int ADDR_W = 16
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_W-1:0]         paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire osc_ctl_pkg::fuse_t        fuse,
    input  wire osc_ctl_pkg::osc_status_t  status_raw,
    input  wire logic                      wait_exec,
    output osc_ctl_pkg::clk_cfg_t          cfg
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        osc_ctl_pkg::osc_status_t sync1;
        osc_ctl_pkg::osc_status_t sync2;
        logic                     fuse_loaded;
        logic [1:0]               monitor_fuse;
        logic [31:0]              osc;
        logic [2:0]               cur_src;
        logic [31:0]              tune;
        logic [31:0]              refc;
        logic [31:0]              trim;
        logic                     key_stage;
        logic                     unlocked;
        logic [3:0]               pb_busy;
        logic [31:0]              rdata;
        logic                     ready;
        logic                     err;
        osc_ctl_pkg::clk_cfg_t    out;
    } state_t;

    state_t q;
    state_t s;

    // Divide ratio for the 3-bit divider codes
    function automatic logic [8:0] div_ratio(input logic [2:0] code);
        div_ratio = (code == 3'h7) ? 9'h100 : (9'h001 << code);
    endfunction

    // Multiplication factor for the PLL multiplier code
    function automatic logic [4:0] mult_factor(input logic [2:0] code);
        case (code)
            3'h7:    mult_factor = 5'h18;
            default: mult_factor = 5'(5'h0F + {2'h0, code});
        endcase
    endfunction

    // Write, clear, set or invert applied to an old value
    function automatic logic [31:0] apply_alias(
        input logic [1:0]  alias_code,
        input logic [31:0] old,
        input logic [31:0] wd
    );
        case (alias_code)
            osc_ctl_pkg::ALIAS_CLR: apply_alias = old & ~wd;
            osc_ctl_pkg::ALIAS_SET: apply_alias = old | wd;
            osc_ctl_pkg::ALIAS_INV: apply_alias = old ^ wd;
            default:                apply_alias = wd;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic        setup;
    logic        access;
    logic [11:0] reg_sel;
    logic [1:0]  alias_code;
    logic        hit_osc;
    logic        hit_tune;
    logic        hit_ref;
    logic        hit_trim;
    logic        hit_key;
    logic        mapped;
    logic        frozen;
    logic        pb_ok;
    logic        wr_osc;
    logic [31:0] osc_view;

    // Bus phases and register select
    assign setup      = psel & ~penable;
    assign access     = psel & penable & q.ready;
    assign reg_sel    = paddr[15:4];
    assign alias_code = paddr[3:2];
    assign hit_osc    = (reg_sel == osc_ctl_pkg::OFF_OSC_CTL[15:4]);
    assign hit_tune   = (reg_sel == osc_ctl_pkg::OFF_FRC_TUNE[15:4]);
    assign hit_ref    = (reg_sel == osc_ctl_pkg::OFF_REF_CTL[15:4]);
    assign hit_trim   = (reg_sel == osc_ctl_pkg::OFF_REF_TRIM[15:4]);
    assign hit_key    = (reg_sel == osc_ctl_pkg::OFF_UNLOCK[15:4]) &&
                        (alias_code == osc_ctl_pkg::ALIAS_WRITE);
    assign mapped     = hit_osc | hit_tune | hit_ref | hit_trim | hit_key;
    assign wr_osc     = access & pwrite & hit_osc;

    // Freeze acts only when the monitor fuse high bit is set
    assign frozen = q.osc[osc_ctl_pkg::POS_FREEZE] &
                    q.monitor_fuse[1];
    assign pb_ok  = (q.pb_busy == 4'h0);

    // Read view of oscillator control with live status bits
    always_comb
    begin
        osc_view = q.osc & osc_ctl_pkg::OSC_WR_MASK;
        osc_view[osc_ctl_pkg::POS_SOSC_READY] = q.sync2.sosc_stable &
            q.osc[osc_ctl_pkg::POS_SOSC_ENABLE];
        osc_view[osc_ctl_pkg::POS_PB_WRITE_OK] = pb_ok;
        osc_view[osc_ctl_pkg::POS_CUR_SOURCE +: 3] = q.cur_src;
        osc_view[osc_ctl_pkg::POS_USB_LOCKED] =
            q.sync2.usb_pll_locked;
        osc_view[osc_ctl_pkg::POS_SYS_LOCKED] =
            q.sync2.sys_pll_locked;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [31:0] nv;
        logic [31:0] keep;
        nv   = 32'h0;
        keep = 32'h0;
        s    = q;

        // Two-flop synchronisers for analog status inputs
        s.sync1 = status_raw;
        s.sync2 = q.sync1;

        // Fuse values captured once after reset release
        if (!q.fuse_loaded)
        begin
            s.fuse_loaded  = 1'b1;
            s.monitor_fuse = fuse.switch_monitor_fuse;
            s.osc[osc_ctl_pkg::POS_NEXT_SOURCE +: 3] =
                fuse.initial_source_fuse;
            s.cur_src = fuse.initial_source_fuse;
            s.osc[osc_ctl_pkg::POS_PLL_POST_DIV +: 3] = fuse.pll_post_divider;
            s.osc[osc_ctl_pkg::POS_PLL_MULT +: 3]     = fuse.pll_multiplier;
            s.osc[osc_ctl_pkg::POS_PB_DIVISOR +: 2]   =
                fuse.periph_bus_divisor;
            s.osc[osc_ctl_pkg::POS_SOSC_ENABLE] = fuse.secondary_osc_enable;
        end

        // Divisor settle countdown
        if (q.pb_busy != 4'h0)
        begin
            s.pb_busy = q.pb_busy - 4'h1;
        end

        // Clock switch completes only once the new source is ready
        if (q.osc[osc_ctl_pkg::POS_SWITCH_REQ] && q.sync2.source_ready)
        begin
            s.cur_src = q.osc[osc_ctl_pkg::POS_NEXT_SOURCE +: 3];
            s.osc[osc_ctl_pkg::POS_SWITCH_REQ] = 1'b0;
        end

        // Divider switch completes at once
        s.refc = q.refc & ~osc_ctl_pkg::REF_HC_MASK;

        // Register writes at the access edge
        if (access && pwrite)
        begin
            if (hit_osc && q.unlocked)
            begin
                nv   = apply_alias(alias_code, osc_view, pwdata);
                keep = ~osc_ctl_pkg::OSC_WR_MASK;
                if (frozen)
                begin
                    keep = keep | osc_ctl_pkg::OSC_FRZ_MASK;
                end
                if (!pb_ok)
                begin
                    keep = keep | osc_ctl_pkg::OSC_PB_MASK;
                end
                if (((nv ^ q.osc) & osc_ctl_pkg::OSC_PB_MASK & ~keep) != 0)
                begin
                    s.pb_busy = osc_ctl_pkg::PB_SETTLE_CYC;
                end
                s.osc = (s.osc & keep) | (nv & ~keep);
            end
            if (hit_tune && q.unlocked)
            begin
                s.tune = apply_alias(alias_code, q.tune, pwdata) &
                         osc_ctl_pkg::TUNE_WR_MASK;
            end
            if (hit_ref)
            begin
                s.refc = apply_alias(alias_code, q.refc, pwdata) &
                         osc_ctl_pkg::REF_WR_MASK;
            end
            if (hit_trim)
            begin
                s.trim = apply_alias(alias_code, q.trim, pwdata) &
                         osc_ctl_pkg::TRIM_WR_MASK;
            end
            // Unlock: key one then key two; any other value restarts
            if (hit_key)
            begin
                s.key_stage = (pwdata == osc_ctl_pkg::UNLOCK_KEY1);
                s.unlocked  = q.key_stage &&
                              (pwdata == osc_ctl_pkg::UNLOCK_KEY2);
            end
            if (hit_osc || hit_tune)
            begin
                s.unlocked = 1'b0;
            end
        end

        // Clock failure sets the flag; set wins over a clear
        if (q.sync2.clock_failed)
        begin
            s.osc[osc_ctl_pkg::POS_CLOCK_FAIL] = 1'b1;
        end

        // Answer one cycle after setup
        s.ready = setup;
        s.err   = setup & ~mapped;
        s.rdata = 32'h0;
        if (setup && !pwrite)
        begin
            if (hit_osc)
            begin
                s.rdata = osc_view;
            end
            else if (hit_tune)
            begin
                s.rdata = q.tune;
            end
            else if (hit_ref)
            begin
                s.rdata = q.refc;
            end
            else if (hit_trim)
            begin
                s.rdata = q.trim;
            end
        end

        // Registered clock configuration outputs
        s.out.active_source    = s.cur_src;
        s.out.requested_source =
            s.osc[osc_ctl_pkg::POS_NEXT_SOURCE +: 3];
        s.out.switch_busy = s.osc[osc_ctl_pkg::POS_SWITCH_REQ];
        s.out.pll_post_div_ratio =
            div_ratio(s.osc[osc_ctl_pkg::POS_PLL_POST_DIV +: 3]);
        s.out.fast_rc_div_ratio =
            div_ratio(s.osc[osc_ctl_pkg::POS_FAST_RC_DIV +: 3]);
        s.out.periph_div_ratio = 4'h1 <<
            s.osc[osc_ctl_pkg::POS_PB_DIVISOR +: 2];
        s.out.pll_mult_factor =
            mult_factor(s.osc[osc_ctl_pkg::POS_PLL_MULT +: 3]);
        s.out.secondary_osc_enable =
            s.osc[osc_ctl_pkg::POS_SOSC_ENABLE];
        s.out.usb_clock_from_rc =
            s.osc[osc_ctl_pkg::POS_USB_FROM_RC];
        s.out.rc_trim_field = s.tune[5:0];
        s.out.enter_sleep = wait_exec &
            q.osc[osc_ctl_pkg::POS_SLEEP_WAIT];
        s.out.enter_idle  = wait_exec &
            ~q.osc[osc_ctl_pkg::POS_SLEEP_WAIT];
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q          <= '0;
            q.osc      <= osc_ctl_pkg::OSC_RESET;
            q.tune     <= osc_ctl_pkg::REG_RESET;
            q.out.fast_rc_div_ratio <= 9'h002;
            q.out.periph_div_ratio  <= 4'h1;
            q.out.pll_post_div_ratio <= 9'h001;
            q.out.pll_mult_factor   <= 5'h0F;
        end
        else
        begin
            q <= s;
        end
    end

    // Outputs straight from flops
    assign prdata  = q.rdata;
    assign pready  = q.ready;
    assign pslverr = q.err;
    assign cfg     = q.out;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_setup_phase;
        psel && !penable;
    endsequence

    sequence s_osc_write_locked;
        wr_osc && !q.unlocked;
    endsequence

    sequence s_switch_done;
        q.osc[osc_ctl_pkg::POS_SWITCH_REQ] && q.sync2.source_ready;
    endsequence

    property p_pready_next;
        @(posedge pclk) disable iff (!presetn)
        s_setup_phase |=> pready;
    endproperty
    a_pready_next: assert property (p_pready_next)
        else $error("pready missing after setup");

    property p_post_div;
        @(posedge pclk) disable iff (!presetn)
        cfg.pll_post_div_ratio ==
            div_ratio(q.osc[osc_ctl_pkg::POS_PLL_POST_DIV +: 3]);
    endproperty
    a_post_div: assert property (p_post_div)
        else $error("pll post divider ratio wrong");

    property p_pb_ratio;
        @(posedge pclk) disable iff (!presetn)
        q.fuse_loaded |-> cfg.periph_div_ratio ==
            (4'h1 << q.osc[osc_ctl_pkg::POS_PB_DIVISOR +: 2]);
    endproperty
    a_pb_ratio: assert property (p_pb_ratio)
        else $error("peripheral divisor ratio wrong");

    property p_pb_blocked;
        @(posedge pclk) disable iff (!presetn)
        (wr_osc && !pb_ok) |=>
            $stable(q.osc[osc_ctl_pkg::POS_PB_DIVISOR +: 2]);
    endproperty
    a_pb_blocked: assert property (p_pb_blocked)
        else $error("divisor changed while not writable");

    property p_locked_write;
        @(posedge pclk) disable iff (!presetn)
        s_osc_write_locked |=> $stable(q.osc) ##1 !q.unlocked;
    endproperty
    a_locked_write: assert property (p_locked_write)
        else $error("write taken without unlock");

    property p_freeze;
        @(posedge pclk) disable iff (!presetn)
        (wr_osc && frozen && q.fuse_loaded) |=>
            $stable(q.osc[osc_ctl_pkg::POS_NEXT_SOURCE +: 3]);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("frozen selection modified");

    // Monitor fuse 0x: a plain write reaches next source despite freeze
    property p_no_freeze;
        @(posedge pclk) disable iff (!presetn)
        (wr_osc && q.unlocked && !q.monitor_fuse[1] &&
            alias_code == osc_ctl_pkg::ALIAS_WRITE) |=>
            q.osc[osc_ctl_pkg::POS_NEXT_SOURCE +: 3] ==
                $past(pwdata[osc_ctl_pkg::POS_NEXT_SOURCE +: 3]);
    endproperty
    a_no_freeze: assert property (p_no_freeze)
        else $error("selection frozen with monitor enabled");

    property p_switch;
        @(posedge pclk) disable iff (!presetn)
        (s_switch_done and !wr_osc) |=>
            cfg.active_source ==
                $past(q.osc[osc_ctl_pkg::POS_NEXT_SOURCE +: 3]) &&
            !q.osc[osc_ctl_pkg::POS_SWITCH_REQ];
    endproperty
    a_switch: assert property (p_switch)
        else $error("clock switch did not complete");

    property p_fail_flag;
        @(posedge pclk) disable iff (!presetn)
        q.sync2.clock_failed |=> q.osc[osc_ctl_pkg::POS_CLOCK_FAIL] [*1];
    endproperty
    a_fail_flag: assert property (p_fail_flag)
        else $error("clock fail flag not set");

    property p_wait_mode;
        @(posedge pclk) disable iff (!presetn)
        wait_exec |=> (cfg.enter_sleep ==
            $past(q.osc[osc_ctl_pkg::POS_SLEEP_WAIT])) &&
            (cfg.enter_idle != cfg.enter_sleep);
    endproperty
    a_wait_mode: assert property (p_wait_mode)
        else $error("wait entered wrong mode");

    // Ready only when enabled and stable at the pin two edges back
    property p_sosc_ready;
        @(posedge pclk) disable iff (!presetn)
        osc_view[osc_ctl_pkg::POS_SOSC_READY] |->
            q.osc[osc_ctl_pkg::POS_SOSC_ENABLE] &&
            $past(status_raw.sosc_stable, 2);
    endproperty
    a_sosc_ready: assert property (p_sosc_ready)
        else $error("secondary ready while disabled");

endmodule // osc_select_ctl

// ==== bench/oscillator_select_control_tb_top.sv ====
// Self-checking bench for the oscillator selection control block
`timescale 1ns/1ps

module oscillator_select_control_tb_top;
    logic                     pclk;
    logic                     presetn;
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [15:0]              paddr;
    logic [31:0]              pwdata;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    osc_ctl_pkg::fuse_t       fuse;
    osc_ctl_pkg::osc_status_t status_raw;
    logic                     wait_exec;
    osc_ctl_pkg::clk_cfg_t    cfg;
    logic [32:0]              exp_q[$];
    logic [31:0]              rnd;
    int                       fail_count;
    int                       tests_run;
    int                       cyc;
    int                       dv[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
    int                       mf[8] = '{15, 16, 17, 18, 19, 20, 21, 24};

    osc_select_ctl osc_select_ctl_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fuse(fuse),
        .status_raw(status_raw), .wait_exec(wait_exec), .cfg(cfg)
    );

    // ----------------------------------------------------------------
    // Clock, timeout and read-data monitor
    // ----------------------------------------------------------------
    always #2.5 pclk = ~pclk;

    // Oldest expected read result against each completed read
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            results();
        end
        if (psel && penable && pready === 1'h1 && !pwrite)
            check("read", {pslverr, prdata}, exp_q.pop_front());
    end

    task automatic check(input string nm, input logic [32:0] s, e);
        tests_run++;
        if (s !== e)
        begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask

    task automatic results();
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // ----------------------------------------------------------------
    // APB master: setup, access held until pready
    // ----------------------------------------------------------------
    task automatic xfer(input logic w, input logic [15:0] a,
                        input logic [31:0] d, input logic [32:0] e);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        if (!w)
            exp_q.push_back(e);
        @(posedge pclk);
        penable <= 1'h1;
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        xfer(1'h1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [15:0] a, input logic [32:0] e);
        xfer(1'h0, a, 32'h0, e);
    endtask

    // Key pair, then one protected write
    task automatic uwr(input logic [15:0] a, input logic [31:0] d);
        wr(osc_ctl_pkg::OFF_UNLOCK, osc_ctl_pkg::UNLOCK_KEY1);
        wr(osc_ctl_pkg::OFF_UNLOCK, osc_ctl_pkg::UNLOCK_KEY2);
        wr(a, d);
    endtask

    // Wait pulse and the low-power request it causes
    task automatic wt(input logic [1:0] e);
        logic [1:0] s;
        s = 2'h0;
        wait_exec <= 1'h1;
        @(posedge pclk);
        wait_exec <= 1'h0;
        repeat (2)
        begin
            @(posedge pclk);
            s = s | {cfg.enter_sleep, cfg.enter_idle};
        end
        check("wait", {31'h0, s}, {31'h0, e});
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 16'h0; pwdata = 32'h0; wait_exec = 0; cyc = 0;
        fail_count = 0; tests_run = 0; rnd = 32'h5F;
        status_raw = '0;
        fuse = {2'h2, 3'h5, 3'h2, 3'h3, 2'h3, 1'h1};
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
        // Fuse-loaded reset image and decoded bus divisor ratio
        rd(16'hF000, 33'h0113B5502);
        rd(16'hF010, 33'h0);
        check("periph_bus_divisor", {29'h0, cfg.periph_div_ratio}, 33'h8);
        wt(2'h1);
        // Unprotected write is dropped, then set alias after unlock
        wr(16'hF008, 32'h00000010);
        rd(16'hF000, 33'h0113B5502);
        uwr(16'hF008, 32'h00000010);
        rd(16'hF000, 33'h0113B5512);
        wt(2'h2);
        // Every PLL post divider, fast RC divider and multiplier code
        for (int i = 0; i < 8; i++)
        begin
            uwr(16'hF000, {2'h0, 3'(i), 3'(i), 3'h0, 2'h3, 3'(i), 5'h00,
                3'h5, 3'h0, 1'h1, 2'h0, 1'h1, 1'h0});
            repeat (2) @(posedge pclk);
            check("podiv", 33'(cfg.pll_post_div_ratio), 33'(dv[i]));
            check("rcdiv", 33'(cfg.fast_rc_div_ratio), 33'(dv[i]));
            check("mult", 33'(cfg.pll_mult_factor), 33'(mf[i]));
        end
        // Freeze holds selections under monitor fuse 1x
        uwr(16'hF008, 32'h00000080);
        uwr(16'hF004, 32'h3F070000);
        rd(16'hF000, 33'h03F3F5592);
        uwr(16'hF004, 32'h00000080);
        // Switch to primary via PLL through the invert alias
        uwr(16'hF00C, 32'h00000601);
        status_raw.source_ready <= 1'h1;
        repeat (6) @(posedge pclk);
        check("active", 33'(cfg.active_source), 33'h3);
        rd(16'hF000, 33'h03F3F3312);
        // Clock failure and oscillator lock status
        status_raw <= 5'h1B; // Stable, PLL locked, failed, ready
        repeat (5) @(posedge pclk);
        rd(16'hF000, 33'h03F7F333A);
        // Reference trim with random data, unmapped place
        rnd = lfsr(rnd);
        wr(16'hF030, rnd);
        rd(16'hF030, {1'h0, rnd & osc_ctl_pkg::TRIM_WR_MASK});
        rd(16'hF050, 33'h100000000);
        // Mid-run reset, monitor fuse 0x: freeze never locks
        fuse.switch_monitor_fuse <= 2'h0;
        presetn <= 1'h0;
        @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
        uwr(16'hF008, 32'h00000080);
        uwr(16'hF000, 32'h110B0082);
        rd(16'hF000, 33'h0114B50AA);
        check("periph_bus_divisor", {29'h0, cfg.periph_div_ratio}, 33'h2);
        repeat (2) @(posedge pclk);
        results();
    end
endmodule // oscillator_select_control_tb_top
